// *** design/wwd_counter.v ***
// Prescaled watchdog counter with its five-bit window view and time-out detect.
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_counter (
  input  wire        i_clk,      // System clock.
  input  wire        i_reset_n,  // Asynchronous reset, active low.
  input  wire        i_tick,     // One-cycle tick of the selected counting clock.
  input  wire        i_clear,    // Hold the count at zero.
  input  wire        i_run,      // Counting is allowed.
  input  wire [4:0]  i_ps,       // Prescale select code.
  output wire [4:0]  o_view,     // Five most significant bits of the period.
  output wire        o_timeout   // Pulse on the last tick of the period.
);

  // Reserved codes above the largest ratio fall back to the shortest one.
  function [4:0] eff_shift;
    input [4:0] ps;
    begin
      eff_shift = (ps > `WWD_PS_MAX) ? 5'h00 : ps;
    end
  endfunction

  reg  [22:0] cnt_r;       // Ticks counted in the current period.
  wire [4:0]  sh;          // Prescale shift in force.
  wire [4:0]  span;        // Period length as a power of two.
  wire [23:0] span_mask;   // Ones over the bits that make up one period.
  wire        at_end;      // Count sits on the last tick of the period.
  wire [22:0] shifted;     // Count with the fine bits dropped.

  assign sh        = eff_shift(i_ps);
  assign span      = sh + `WWD_PS_BASE_SHIFT;
  assign span_mask = (24'h000001 << span) - 24'h000001;
  assign at_end    = (({1'b0, cnt_r} | ~span_mask) == 24'hFFFFFF);
  assign shifted   = cnt_r >> sh;
  assign o_view    = shifted[4:0];
  assign o_timeout = i_run & i_tick & at_end & ~i_clear;

  // The period wraps by itself at its last tick.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 23'h000000;
    end else if (i_clear) begin
      cnt_r <= 23'h000000;
    end else if (i_run && i_tick) begin
      cnt_r <= at_end ? 23'h000000 : cnt_r + 23'h000001;
    end
  end

endmodule

// *** design/wwd_top.v ***
// Windowed watchdog: window check, arming, clearing, sleep wake and control registers.
`timescale 1ns/1ps
`include "wwd_map.vh"

// How it works
// - Clear in closed window resets like time-out.
// - Window from config, or register when 111.
// - Window judged on counter's top five bits.
// - Violation drives active-low violation flag zero.
// - Counter cleared on every listed event.
// - Reading primary control arms; clear needs arming.
// - Unarmed clear is a violation unless window code is 111.
// - Clear on sleep entry and exit.
// - Crystal clock holds counter until start-up ends.
// - Sleep time-out wakes, updates status flags.
// - Oscillator divider change leaves counter alone.
// - Clear in off, soft-off, sleep-off, oscillator fail.
// - Prescale code doubles ratio; reserved give 1:32.
// - Prescale resets to 01011 or config value.
// - Prescale read-only unless config all ones.
// - Soft enable matters only in mode 01.
// - Clock source picks low, medium, secondary oscillator.
// - Clock source resets 000 or config value, writable only config 111.
// - Window code sets closed fraction in eighths.
// - Window field resets to config; writable when 111.
// - Secondary oscillator restart waits 1024 cycles.
// - Mode config decodes on, awake-only, soft, off.
// - Window opens when view reaches code threshold.
// - Armed status bit is readable.

module wwd_top (
  input  wire        i_clk,              // System clock, 100 MHz.
  input  wire        i_reset_n,          // Power-on reset, asynchronous, active low.
  input  wire        i_hsel,             // AHB slave select.
  input  wire [31:0] i_haddr,            // AHB address.
  input  wire [1:0]  i_htrans,           // AHB transfer type.
  input  wire        i_hwrite,           // AHB write strobe.
  input  wire [2:0]  i_hsize,            // AHB transfer size.
  input  wire [31:0] i_hwdata,           // AHB write data.
  input  wire        i_hready,           // AHB bus ready.
  output reg  [31:0] o_hrdata,           // AHB read data.
  output reg         o_hreadyout,        // AHB slave ready.
  output reg         o_hresp,            // AHB response, always OKAY.
  input  wire [1:0]  i_mode_cfg,         // Watchdog mode configuration.
  input  wire [4:0]  i_prescale_cfg,     // Prescale configuration field.
  input  wire [2:0]  i_clksrc_cfg,       // Clock source configuration field.
  input  wire [2:0]  i_window_cfg,       // Window configuration field.
  input  wire        i_lfosc_clk,        // Low-frequency internal oscillator pin.
  input  wire        i_mfosc_clk,        // Medium-frequency internal oscillator pin.
  input  wire        i_secondary_oscillator_clk,         // Secondary oscillator pin.
  input  wire        i_clear_instr,      // Clear instruction executed, pulse.
  input  wire        i_sleep_enter,      // Core enters sleep, pulse.
  input  wire        i_wake_int,         // Sleep left by interrupt, pulse.
  input  wire        i_xtal_sysclk,      // System clock is a crystal type.
  input  wire        i_ost_done,         // Oscillator start-up wait ended, pulse.
  input  wire        i_osc_fail,         // Oscillator failure detected, pulse.
  input  wire        i_wv_flag_set,      // Firmware sets the violation flag, pulse.
  input  wire        i_watchdog_reset_flag_flag_set,    // Firmware sets the watchdog reset flag, pulse.
  output reg         o_wdt_reset,        // Watchdog reset request, pulse.
  output reg         o_wake,             // Wake request from sleep time-out, pulse.
  output reg         o_window_viol_n,    // Window violation flag, active low.
  output reg         o_expired_n,        // Watchdog expired flag, active low.
  output reg         o_sleep_entered_n,  // Sleep entered flag, active low.
  output reg         o_wdt_reset_flag_n, // Watchdog event flag, active low.
  output reg         o_armed             // Watchdog armed status.
);

  // Control and state registers.
  reg        loaded_r;      // Configuration values captured after reset.
  reg  [4:0] ps_r;          // Prescale select field.
  reg        sen_r;         // Soft enable bit.
  reg  [2:0] cs_r;          // Clock source field.
  reg  [2:0] win_r;         // Window field.
  reg        asleep_r;      // Core is in sleep.
  reg        ost_hold_r;    // Counter held until start-up wait ends.
  reg  [10:0] secondary_oscillator_wait_r;  // Secondary oscillator restart cycles left.
  reg        armed_r;       // Watchdog armed by a read.

  // Oscillator pin synchronisers and edge detect.
  reg  [2:0] osc_s1_r;      // First synchroniser stage.
  reg  [2:0] osc_s2_r;      // Second synchroniser stage.
  reg  [2:0] osc_s3_r;      // Delayed copy for edge detect.

  // Bus data phase state.
  reg        wr_pend_r;     // A write data phase is under way.
  reg  [7:0] wr_addr_r;     // Address of that write.
  reg  [31:0] rdata;        // Read value for the address phase.

  wire [2:0] osc_rise;      // Rising edge of each oscillator.
  reg        tick;          // Tick of the selected counting clock.
  reg        enabled;       // Watchdog active in this mode.
  wire [2:0] eff_win;       // Window setting in force.
  wire       windowed;      // Window is not always open.
  wire [4:0] view;          // Top five bits of the count.
  wire       win_open;      // View has reached the opening threshold.
  wire       timeout;       // Counter reached the end of the period.
  wire       addr_acc;      // An address phase is taken.
  wire       arm_read;      // Read of the primary control register.
  wire       wr_ctrl0;      // Write data phase to the primary register.
  wire       wr_ctrl1;      // Write data phase to the secondary register.
  wire       clr_seen;      // A clear instruction counts while enabled.
  wire       accepted;      // Clear instruction accepted.
  wire       violation;     // Clear instruction rejected.
  wire       secondary_oscillator_wait;     // Secondary oscillator still restarting.
  wire       cnt_clear;     // Any reason to clear the counter.
  wire       to_reset;      // Time-out while awake.
  wire       to_wake;       // Time-out while asleep.

  assign osc_rise = osc_s2_r & ~osc_s3_r;

  // Level pins pass two flops; the edge detect compares the second stage with its delayed copy.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_s1_r <= 3'h0;
      osc_s2_r <= 3'h0;
      osc_s3_r <= 3'h0;
    end else begin
      osc_s1_r <= {i_secondary_oscillator_clk, i_mfosc_clk, i_lfosc_clk};
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Counting clock choice; reserved codes give no tick, so the count stalls.
  always @* begin
    case (cs_r)
      `WWD_CS_LFOSC: tick = osc_rise[0];
      `WWD_CS_MFOSC: tick = osc_rise[1];
      `WWD_CS_SECONDARY_OSCILLATOR:  tick = osc_rise[2];
      default:       tick = 1'b0;
    endcase
  end

  // Mode decode; soft enable is looked at only in the soft mode.
  always @* begin
    case (i_mode_cfg)
      `WWD_MODE_ON:    enabled = 1'b1;
      `WWD_MODE_AWAKE: enabled = ~asleep_r;
      `WWD_MODE_SOFT:  enabled = sen_r;
      default:         enabled = 1'b0;
    endcase
  end

  // Window setting: configuration unless it leaves the choice to software.
  assign eff_win  = (i_window_cfg == `WWD_CFG3_OPEN) ? win_r : i_window_cfg;
  assign windowed = (eff_win != `WWD_WIN_ALWAYS);
  // Each lower code closes one more eighth: threshold is the inverted code times four.
  assign win_open = (view >= {~eff_win, 2'b00});

  // Bus decode; only whole-word transfers are served.
  assign addr_acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == `WWD_HSIZE_WORD);
  assign arm_read = addr_acc & ~i_hwrite & (i_haddr[7:0] == `WWD_OFS_CTRL0);
  assign wr_ctrl0 = wr_pend_r & (wr_addr_r == `WWD_OFS_CTRL0);
  assign wr_ctrl1 = wr_pend_r & (wr_addr_r == `WWD_OFS_CTRL1);

  // Clear instruction judgement; with a window set, an unarmed clear fails even while it is open.
  assign clr_seen  = i_clear_instr & enabled & loaded_r;
  assign accepted  = clr_seen & (~windowed | (armed_r & win_open));
  assign violation = clr_seen & windowed & ~(armed_r & win_open);

  assign secondary_oscillator_wait = (secondary_oscillator_wait_r != 11'h000);
  assign to_reset  = timeout & ~asleep_r;
  assign to_wake   = timeout & asleep_r;

  // Every clearing event; a divider change is not among them and has no input.
  // The time-out is left out here: it is gated by this clear, and the period wraps itself.
  assign cnt_clear = ~loaded_r | ~enabled | accepted | violation
                   | i_sleep_enter | i_wake_int
                   | ost_hold_r
                   | i_osc_fail
                   | wr_ctrl0 | wr_ctrl1;

  wwd_counter u_counter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_tick    (tick),
    .i_clear   (cnt_clear),
    .i_run     (enabled & ~secondary_oscillator_wait),
    .i_ps      (ps_r),
    .o_view    (view),
    .o_timeout (timeout)
  );

  // Read multiplexer; unmapped addresses and unused bits read zero.
  always @* begin
    rdata = 32'h00000000;
    case (i_haddr[7:0])
      `WWD_OFS_CTRL0: begin
        rdata[`WWD_PS_MSB:`WWD_PS_LSB] = ps_r;
        rdata[`WWD_SEN_BIT]            = sen_r;
      end
      `WWD_OFS_CTRL1: begin
        rdata[`WWD_CS_MSB:`WWD_CS_LSB]   = cs_r;
        rdata[`WWD_WIN_MSB:`WWD_WIN_LSB] = win_r;
      end
      `WWD_OFS_STATUS: begin
        rdata[`WWD_ST_VIEW_MSB:`WWD_ST_VIEW_LSB] = view;
        rdata[`WWD_ST_ARMED_BIT]  = armed_r;
        rdata[`WWD_ST_EXP_BIT]    = o_expired_n;
        rdata[`WWD_ST_SLP_BIT]    = o_sleep_entered_n;
        rdata[`WWD_ST_WATCHDOG_RESET_FLAG_BIT]   = o_wdt_reset_flag_n;
        rdata[`WWD_ST_WV_BIT]     = o_window_viol_n;
        rdata[`WWD_ST_ASLEEP_BIT] = asleep_r;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

  // AHB slave: zero wait states, read data registered at the address phase.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (i_hready) begin
        wr_pend_r <= addr_acc & i_hwrite;
        if (addr_acc) begin
          wr_addr_r <= i_haddr[7:0];
        end
        if (addr_acc && !i_hwrite) begin
          o_hrdata <= rdata;
        end
      end
    end
  end

  // Control fields. Reset leaves constants; the configuration is caught one
  // edge after release, because an asynchronous reset may not load a port.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loaded_r <= 1'b0;
      ps_r     <= `WWD_PS_DEFAULT;
      sen_r    <= 1'b0;
      cs_r     <= `WWD_CS_DEFAULT;
      win_r    <= `WWD_WIN_ALWAYS;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      ps_r     <= (i_prescale_cfg == `WWD_PS_CFG_OPEN) ? `WWD_PS_DEFAULT
                                                      : i_prescale_cfg;
      cs_r     <= (i_clksrc_cfg == `WWD_CFG3_OPEN) ? `WWD_CS_DEFAULT
                                                  : i_clksrc_cfg;
      win_r    <= i_window_cfg;
    end else begin
      if (wr_ctrl0) begin
        sen_r <= i_hwdata[`WWD_SEN_BIT];
        if (i_prescale_cfg == `WWD_PS_CFG_OPEN) begin
          ps_r <= i_hwdata[`WWD_PS_MSB:`WWD_PS_LSB];
        end
      end
      if (wr_ctrl1) begin
        if (i_clksrc_cfg == `WWD_CFG3_OPEN) begin
          cs_r <= i_hwdata[`WWD_CS_MSB:`WWD_CS_LSB];
        end
        if (i_window_cfg == `WWD_CFG3_OPEN) begin
          win_r <= i_hwdata[`WWD_WIN_MSB:`WWD_WIN_LSB];
        end
      end
    end
  end

  // Sleep tracking and the start-up hold after a crystal-clocked wake.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      asleep_r   <= 1'b0;
      ost_hold_r <= 1'b0;
    end else begin
      if (i_wake_int || to_wake) begin
        asleep_r <= 1'b0;
      end else if (i_sleep_enter) begin
        asleep_r <= 1'b1;
      end
      // The wake that starts the hold wins over a stale end pulse.
      if ((i_wake_int || to_wake) && i_xtal_sysclk) begin
        ost_hold_r <= 1'b1;
      end else if (i_ost_done) begin
        ost_hold_r <= 1'b0;
      end
    end
  end

  // A reset from time-out with the secondary oscillator as source restarts it; counting waits
  // for its start-up cycles, which stretches the effective reset period.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      secondary_oscillator_wait_r <= 11'h000;
    end else if (to_reset && cs_r == `WWD_CS_SECONDARY_OSCILLATOR) begin
      secondary_oscillator_wait_r <= `WWD_SECONDARY_OSCILLATOR_START_CYC;
    end else if (secondary_oscillator_wait && osc_rise[2]) begin
      secondary_oscillator_wait_r <= secondary_oscillator_wait_r - 11'h001;
    end
  end

  // Arming: a fresh read wins over a clear in the same cycle.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_r <= 1'b0;
    end else if (arm_read) begin
      armed_r <= 1'b1;
    end else if (cnt_clear || timeout) begin
      armed_r <= 1'b0;
    end
  end

  // Event outputs and sticky active-low status flags. Hardware events win
  // over a set in the same cycle, so no event is lost.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wdt_reset        <= 1'b0;
      o_wake             <= 1'b0;
      o_window_viol_n    <= 1'b1;
      o_expired_n        <= 1'b1;
      o_sleep_entered_n  <= 1'b1;
      o_wdt_reset_flag_n <= 1'b1;
      o_armed            <= 1'b0;
    end else begin
      o_wdt_reset <= violation | to_reset;
      o_wake      <= to_wake;
      o_armed     <= armed_r;
      if (violation) begin
        o_window_viol_n <= 1'b0;
      end else if (i_wv_flag_set) begin
        o_window_viol_n <= 1'b1;
      end
      if (timeout) begin
        o_expired_n <= 1'b0;
      end else if (accepted) begin
        o_expired_n <= 1'b1;
      end
      if (i_sleep_enter) begin
        o_sleep_entered_n <= 1'b0;
      end else if (accepted) begin
        o_sleep_entered_n <= 1'b1;
      end
      if (timeout) begin
        o_wdt_reset_flag_n <= 1'b0;
      end else if (i_watchdog_reset_flag_flag_set) begin
        o_wdt_reset_flag_n <= 1'b1;
      end
    end
  end

endmodule

// *** include/wwd_map.vh ***
// Register offsets, field positions, reset values and counts for the windowed watchdog.
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// Byte offsets of the registers on the AHB-Lite bus (low address byte).
`define WWD_OFS_CTRL0      8'h00
`define WWD_OFS_CTRL1      8'h04
`define WWD_OFS_STATUS     8'h08

// Field positions inside the primary control register.
`define WWD_PS_MSB         5
`define WWD_PS_LSB         1
`define WWD_SEN_BIT        0

// Field positions inside the secondary control register.
`define WWD_CS_MSB         6
`define WWD_CS_LSB         4
`define WWD_WIN_MSB        2
`define WWD_WIN_LSB        0

// Field positions inside the status register.
`define WWD_ST_VIEW_MSB    7
`define WWD_ST_VIEW_LSB    3
`define WWD_ST_ARMED_BIT   2
`define WWD_ST_EXP_BIT     8
`define WWD_ST_SLP_BIT     9
`define WWD_ST_WATCHDOG_RESET_FLAG_BIT    10
`define WWD_ST_WV_BIT      11
`define WWD_ST_ASLEEP_BIT  12

// Reset values and special configuration codes.
`define WWD_PS_DEFAULT     5'h0B
`define WWD_PS_CFG_OPEN    5'h1F
`define WWD_PS_MAX         5'h12
`define WWD_PS_BASE_SHIFT  5'h05
`define WWD_CFG3_OPEN      3'h7
`define WWD_CS_DEFAULT     3'h0
`define WWD_WIN_ALWAYS     3'h7

// Clock source codes.
`define WWD_CS_LFOSC       3'h0
`define WWD_CS_MFOSC       3'h1
`define WWD_CS_SECONDARY_OSCILLATOR        3'h2

// Mode configuration codes.
`define WWD_MODE_OFF       2'h0
`define WWD_MODE_SOFT      2'h1
`define WWD_MODE_AWAKE     2'h2
`define WWD_MODE_ON        2'h3

// Secondary oscillator restart wait, in its own cycles.
`define WWD_SECONDARY_OSCILLATOR_START_CYC 11'h400

// AHB encodings used by the slave.
`define WWD_HSIZE_WORD     3'h2

`endif

// *** test/tb_top.sv ***
// Self-checking bench for the windowed watchdog with a core model on the far side.
`timescale 1ns/1ps
`include "wwd_map.vh"
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, xtal = 1'b0; // Clock, reset, crystal flag.
  logic [1:0]  mode = 2'h3;                           // Mode configuration.
  logic [4:0]  pscfg = 5'h1F;                         // Prescale configuration.
  logic [2:0]  cscfg = 3'h7, wincfg = 3'h7;           // Source and window configuration.
  wire         hsel, hwrite, clr, rdy, resp, wrst, wake, vn, en, sn, rn, armed;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [5:0]  ev;
  wire  [2:0]  osc;
  int          n_fail = 0, checked = 0, i, k;
  logic [31:0] d, seed = 32'hF897;
  logic [4:0]  pst [3] = '{5'h00, 5'h01, 5'h13};                     // Prescale codes.
  logic [4:0]  mt [7] = '{5'h19, 5'h11, 5'h12, 5'h08, 5'h0D, 5'h04, 5'h1B}; // Mode cases.
  always #5 clk = ~clk;
  wwd_core_model wwd_core_model_i (.i_clk(clk), .i_hready(rdy), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata),
    .o_clear(clr), .o_ev(ev), .o_osc(osc));
  wwd_top wwd_top_i (.i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
    .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp), .i_mode_cfg(mode),
    .i_prescale_cfg(pscfg), .i_clksrc_cfg(cscfg), .i_window_cfg(wincfg), .i_lfosc_clk(osc[0]),
    .i_mfosc_clk(osc[1]), .i_secondary_oscillator_clk(osc[2]), .i_clear_instr(clr), .i_sleep_enter(ev[0]),
    .i_wake_int(ev[1]), .i_xtal_sysclk(xtal), .i_ost_done(ev[2]), .i_osc_fail(ev[3]),
    .i_wv_flag_set(ev[4]), .i_watchdog_reset_flag_flag_set(ev[5]), .o_wdt_reset(wrst), .o_wake(wake),
    .o_window_viol_n(vn), .o_expired_n(en), .o_sleep_entered_n(sn), .o_wdt_reset_flag_n(rn),
    .o_armed(armed));
  // Pseudo-random source for written data.
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Time-out period in system cycles with the low oscillator ticking every eight cycles.
  function int per(input logic [4:0] p);
    per = (p > `WWD_PS_MAX) ? 256 : 8 << (5 + p);
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rd(input logic [7:0] a);
    wwd_core_model_i.xfer(1'b0, a, 32'h0, d);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    wwd_core_model_i.xfer(1'b1, a, v, d);
  endtask
  task ev_pulse(input logic c, input logic [5:0] e);
    wwd_core_model_i.pulse(c, e);
  endtask
  // Configuration changes only while reset is held, since they are static levels.
  task rst(input logic [1:0] m, input logic [4:0] p, input logic [2:0] c, input logic [2:0] w);
    @(posedge clk);
    {rst_n, mode, pscfg, cscfg, wincfg} <= {1'b0, m, p, c, w};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  // Counts edges until a reset or wake pulse is seen, giving up at the limit.
  task wait_ev(input int lim, output int n);
    n = 0;
    do begin @(posedge clk); n++; end while (wrst !== 1'b1 && wake !== 1'b1 && n < lim);
  endtask
  initial begin
    #500000;
    n_fail++;
    results();
  end
  initial begin
    rst(2'h3, 5'h1F, 3'h7, 3'h7);
    rd(`WWD_OFS_CTRL0); chk("ctrl0 reset", d, 32'h16);
    rd(`WWD_OFS_CTRL1); chk("ctrl1 reset", d, 32'h07);
    rd(`WWD_OFS_STATUS); chk("status reset", d[12:8], 5'h0F);
    rd(8'h0C); chk("unmapped", d, 32'h0);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`WWD_OFS_CTRL0, seed); rd(`WWD_OFS_CTRL0); chk("ctrl0 rw", d, seed & 32'h3F);
      wr(`WWD_OFS_CTRL1, seed); rd(`WWD_OFS_CTRL1); chk("ctrl1 rw", d, seed & 32'h77);
    end
    wr(`WWD_OFS_CTRL1, 32'h07);
    for (i = 0; i < 3; i++) begin
      wr(`WWD_OFS_CTRL0, {26'h0, pst[i], 1'b0});
      wait_ev(20000, k); wait_ev(20000, k); chk("period", k, per(pst[i]));
    end
    wr(`WWD_OFS_CTRL1, 32'h03);
    wr(`WWD_OFS_CTRL0, 32'h00);
    ev_pulse(1'b1, 6'h00); #1 chk("unarmed clear", {wrst, vn}, 2'b10);
    ev_pulse(1'b0, 6'h10); #1 chk("flag set", vn, 1'b1);
    wwd_core_model_i.arm_clear(); #1 chk("closed clear", wrst, 1'b1);
    k = 0;
    do begin rd(`WWD_OFS_STATUS); k++; end while (d[7:3] < 5'h10 && k < 200);
    wwd_core_model_i.arm_clear(); #1 chk("open clear", {wrst, en}, 2'b01);
    rd(`WWD_OFS_STATUS); chk("cleared view", {d[7:4], d[2]}, 5'h00);
    ev_pulse(1'b0, 6'h01); wait_ev(400, k);
    chk("sleep wake", {wake, wrst, sn, rn}, 4'b1000);
    chk("sleep period", (k > 240 && k < 270), 1'b1);
    xtal <= 1'b1;
    ev_pulse(1'b0, 6'h01); ev_pulse(1'b0, 6'h02);
    wait_ev(400, k); chk("start-up hold", k, 400);
    ev_pulse(1'b0, 6'h04); wait_ev(400, k); chk("start-up end", wrst, 1'b1);
    xtal <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rst(mt[i][4:3], 5'h00, 3'h7, 3'h7);
      wr(`WWD_OFS_CTRL0, {31'h0, mt[i][2]});
      if (mt[i][1]) ev_pulse(1'b0, 6'h01);
      wait_ev(400, k); chk("mode", k < 400, mt[i][0]);
    end
    rst(2'h3, 5'h03, 3'h1, 3'h2);
    seed = lfsr(seed);
    wr(`WWD_OFS_CTRL0, seed); rd(`WWD_OFS_CTRL0); chk("ps fixed", d, {31'h3, seed[0]});
    wr(`WWD_OFS_CTRL1, seed); rd(`WWD_OFS_CTRL1); chk("ctrl1 fixed", d, 32'h12);
    ev_pulse(1'b1, 6'h00); #1 chk("fixed window", wrst, 1'b1);
    results();
  end
endmodule

// *** test/wwd_core_model.sv ***
// Processor core model: bus master, clear instruction, core events and oscillator pins.
`timescale 1ns/1ps
`include "wwd_map.vh"
module wwd_core_model (
  input  wire        i_clk,    // System clock.
  input  wire        i_hready, // Bus ready from the slave.
  input  wire [31:0] i_hrdata, // Read data from the slave.
  output reg         o_hsel,   // Slave select.
  output reg  [31:0] o_haddr,  // Address.
  output reg  [1:0]  o_htrans, // Transfer type.
  output reg         o_hwrite, // Write strobe.
  output reg  [31:0] o_hwdata, // Write data.
  output reg         o_clear,  // Clear instruction pulse.
  output reg  [5:0]  o_ev,     // Sleep, wake, start-up end, fail, two flag sets.
  output wire [2:0]  o_osc     // Oscillator pins: secondary, medium, low.
);
  reg [3:0] div_r = 4'h0; // Free divider; slow enough for the two-flop pin sync.
  assign o_osc = {div_r[1], div_r[3], div_r[2]};
  initial begin
    {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata, o_clear, o_ev} = '0;
  end
  // The oscillators run free; the low one ticks every eight system cycles.
  always @(posedge i_clk) begin
    div_r <= div_r + 4'h1;
  end
  // One word transfer; each phase is held until ready is seen at an edge.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    {o_hsel, o_htrans, o_hwrite, o_haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
    do @(posedge i_clk); while (i_hready !== 1'b1);
    {o_hsel, o_htrans, o_hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge i_clk); while (i_hready !== 1'b1);
    rd = i_hrdata;
  endtask
  // One-cycle pulse of the clear instruction and of the chosen core events.
  task pulse(input logic c, input logic [5:0] e);
    @(posedge i_clk);
    {o_clear, o_ev} <= {c, e};
    @(posedge i_clk);
    {o_clear, o_ev} <= 7'h00;
  endtask
  // Software arms with a read of the primary control register, then clears.
  task arm_clear();
    logic [31:0] t;
    xfer(1'b0, `WWD_OFS_CTRL0, 32'h0, t);
    pulse(1'b1, 6'h00);
  endtask
endmodule

// *** test/wwd_monitor.sv ***
// Concurrent checks on the windowed watchdog top-level ports.
`timescale 1ns/1ps
`include "wwd_map.vh"
module wwd_monitor (
  input wire        i_clk,           // System clock.
  input wire        i_reset_n,       // Reset, active low.
  input wire        i_hsel,          // Bus select.
  input wire [31:0] i_haddr,         // Bus address.
  input wire [1:0]  i_htrans,        // Transfer type.
  input wire        i_hwrite,        // Write strobe.
  input wire [2:0]  i_hsize,         // Transfer size.
  input wire        i_hready,        // Bus ready.
  input wire [1:0]  i_mode_cfg,      // Mode configuration.
  input wire [2:0]  i_window_cfg,    // Window configuration.
  input wire        i_clear_instr,   // Clear instruction.
  input wire        i_wv_flag_set,   // Firmware sets the violation flag.
  input wire        o_wdt_reset,     // Reset request.
  input wire        o_wake,          // Wake request.
  input wire        o_window_viol_n, // Violation flag.
  input wire        o_armed          // Armed status.
);
  // A word transfer that the slave takes at this edge.
  wire tkn  = i_hsel && i_htrans[1] && i_hready && (i_hsize == `WWD_HSIZE_WORD);
  wire rd0  = tkn && !i_hwrite && (i_haddr[7:0] == `WWD_OFS_CTRL0);
  wire wr01 = tkn && i_hwrite && (i_haddr[7:0] == `WWD_OFS_CTRL0 || i_haddr[7:0] == `WWD_OFS_CTRL1);
  // The window in force comes from the fixed field whenever it is not all ones.
  wire won  = (i_mode_cfg == `WWD_MODE_ON) && (i_window_cfg != `WWD_CFG3_OPEN);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  arm_needs_read_a: assert property ($rose(o_armed) |-> $past(rd0, 2))
    else $error("armed without a primary control read");
  unarmed_clear_a: assert property (won && i_clear_instr && !o_armed && !$past(rd0) |=> o_wdt_reset)
    else $error("unarmed clear gave no reset");
  viol_with_reset_a: assert property ($fell(o_window_viol_n) |-> o_wdt_reset)
    else $error("violation flag fell without reset");
  viol_sticky_a: assert property (!o_window_viol_n && !i_wv_flag_set |=> !o_window_viol_n)
    else $error("violation flag rose by itself");
  viol_release_a: assert property (i_wv_flag_set && !i_clear_instr |=> o_window_viol_n)
    else $error("firmware set of violation flag lost");
  clear_disarms_a: assert property (i_clear_instr && i_mode_cfg == `WWD_MODE_ON && !rd0 |=> ##1 !o_armed)
    else $error("armed state kept after clear");
  write_disarms_a: assert property (wr01 ##1 !rd0 |=> ##1 !o_armed)
    else $error("armed state kept after control write");
  wake_not_reset_a: assert property (o_wake |-> !o_wdt_reset)
    else $error("sleep time-out also reset");
  cover property ($fell(o_window_viol_n));
  cover property (o_wake);
  cover property ($rose(o_armed));
endmodule
bind wwd_top wwd_monitor wwd_monitor_i (.i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hsize, .i_hready, .i_mode_cfg, .i_window_cfg, .i_clear_instr, .i_wv_flag_set,
  .o_wdt_reset, .o_wake, .o_window_viol_n, .o_armed);
